// ===== bench/slsc_loop_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Reference clock source for three loops
// ----------------------------------------
module slsc_loop_model #(
	parameter int HALF = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Run control {aux2, aux1, main}
	input wire logic [2:0] refRun,
	// Reference clocks
	output logic [2:0] refIn
);
	int cnt [3];
	// A stopped clock stands low, so no stray pulse reaches the timers
	always_ff @(posedge clk or posedge rst) begin
		for (int i = 0; i < 3; i++) begin
			if (rst || !refRun[i]) begin
				refIn[i] <= 1'b0;
				cnt[i] <= 0;
			end else if (cnt[i] == HALF - 1) begin
				refIn[i] <= ~refIn[i];
				cnt[i] <= 0;
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
endmodule : slsc_loop_model

// ===== bench/synth_lock_speedup_control_test.sv
`timescale 1ns/10ps
module synth_lock_speedup_control_test;
	import slsc_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, st;
	logic [14:0] tapVec;
	logic [2:0] refIn, refRun, lockIn, switchLowZ, boostEn, powerEn, pat;
	logic lockIndicatorOut, extPulseMode, ok, e;
	logic [10:0] mainNm1;
	logic [4:0] mainNm2;
	logic [3:0] mainRatio, auxRatio;
	int fail_count = 0;
	int comparisons = 0;
	int k;
	logic [4:0] tmCode [21] = '{TM_M_PRE, TM_M_C11, TM_M_C5, TM_M_DN,
		TM_M_UP, TM_M_TMR, TM_A1_PRE, TM_A1_C11, TM_A1_C3, TM_A1_DN,
		TM_A1_UP, TM_A1_TMR, TM_A2_PRE, TM_A2_C11, TM_A2_C3, TM_A2_DN,
		TM_A2_UP, TM_A2_TMR, TM_REF_M, TM_REF_A1, TM_REF_A2};
	// Tap bit per code; 15 means idle source, expected low
	int tmSrc [21] = '{0, 1, 2, 3, 4, 15, 5, 6, 7, 8, 9, 15, 10, 11, 12,
		13, 14, 15, 15, 15, 15};
	// ----------------------------------------
	// Design and far side
	// ----------------------------------------
	slsc_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mainTap(tapVec[4:0]),
		.aux1Tap(tapVec[9:5]), .aux2Tap(tapVec[14:10]), .refIn(refIn),
		.lockIn(lockIn), .lockIndicatorOut(lockIndicatorOut),
		.mainNm1(mainNm1), .mainNm2(mainNm2), .switchLowZ(switchLowZ),
		.boostEn(boostEn), .mainRatio(mainRatio), .auxRatio(auxRatio),
		.powerEn(powerEn), .extPulseMode(extPulseMode));
	slsc_loop_model loops (.clk(clk), .rst(rst), .refRun(refRun),
		.refIn(refIn));
	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task end_sim;
		if (fail_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : chk
	// One APB transfer; the request holds until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic er);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) begin
			fail_count++;
			end_sim();
		end
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, st, e);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0, st, e);
		chk(st, x);
		chk(e, xe);
	endtask : rdc
	// Device word plus strobe
	task prog3(input logic [2:0] en, input logic [1:0] u,
		input logic [5:0] v);
		wr(OFF_WORD3, {10'h0, v, u, en, 11'h0});
		wr(OFF_STROBE, 32'h0);
	endtask : prog3
	task setIn(input logic [2:0] lk, input logic [14:0] tp);
		@(posedge clk);
		lockIn <= lk;
		tapVec <= tp;
	endtask : setIn
	task look(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : look
	task waitBoost(input int i, input int lim, output logic found);
		found = 1'b0;
		repeat (lim) begin
			@(negedge clk);
			if (boostEn[i] === 1'b1) begin
				found = 1'b1;
				break;
			end
		end
	endtask : waitBoost
	// Reference edges seen while speed-up stands
	task countBoost(input int i, output int n);
		logic prev;
		int g;
		n = 0;
		g = 0;
		prev = refIn[i];
		while (boostEn[i] === 1'b1 && g < 2000) begin
			@(negedge clk);
			if (refIn[i] === 1'b1 && prev === 1'b0)
				n++;
			prev = refIn[i];
			g++;
		end
		chk(g < 2000, 1);
		// A speed-up that never ends is a hang: stop the run here
		if (g >= 2000)
			end_sim();
	endtask : countBoost
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		tapVec = '0;
		lockIn = '0;
		refRun = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		look(1);
		chk({mainRatio, auxRatio, powerEn, boostEn}, 14'h0440);
		rdc(8'h18, 32'h0, 1'b1);
		// Ratio codes for main and shared aux
		for (int c = 0; c < 4; c++) begin
			wr(OFF_WORD1, 32'(c) << F_LSB);
			wr(OFF_WORD2, 32'(3 - c) << K_LSB);
			wr(OFF_STROBE, 32'h0);
			look(2);
			chk(mainRatio, 4'h1 << c);
			chk(auxRatio, 4'h1 << (3 - c));
		end
		// Lock select with all loops powered, then with loops switched off
		for (int u = 0; u < 4; u++) begin
			prog3(3'h7, u[1:0], 6'h00);
			for (int j = 0; j < 2; j++) begin
				pat = j ? 3'b101 : 3'b010;
				setIn(pat, 15'h0);
				look(4);
				chk(lockIndicatorOut, (u == 3) ? &pat : pat[u]);
			end
		end
		prog3(3'h5, 2'h3, 6'h00);
		setIn(3'b101, 15'h0);
		look(4);
		chk(lockIndicatorOut, 1);
		chk(powerEn, 3'h5);
		prog3(3'h0, 2'h3, 6'h00);
		setIn(3'b111, 15'h0);
		look(4);
		chk(lockIndicatorOut, 0);
		// Test routes; references stopped, timers idle
		for (int i = 0; i < 21; i++) begin
			prog3(3'h7, 2'h0, {1'b0, tmCode[i]});
			setIn(3'h0, (tmSrc[i] < 15) ? 15'h1 << tmSrc[i] : 15'h0);
			look(4);
			chk(lockIndicatorOut, tmSrc[i] < 15);
			setIn(3'h7, (tmSrc[i] < 15) ? ~(15'h1 << tmSrc[i]) : 15'h7FFF);
			look(4);
			chk(lockIndicatorOut, 0);
		end
		prog3(3'h7, 2'h0, 6'h20);
		look(2);
		chk(extPulseMode, 1);
		prog3(3'h7, 2'h0, 6'h00);
		look(2);
		chk(extPulseMode, 0);
		// Main speed-up; new word waits in holding register
		wr(OFF_WORD0, {10'h0, 6'd3, 11'h123, 5'h0A});
		chk(mainNm1, 11'h000);
		rdc(OFF_WORD0, {10'h0, 6'd3, 11'h123, 5'h0A}, 1'b0);
		wr(OFF_STROBE, 32'h0);
		look(4);
		apb(1'b0, OFF_STATUS, 32'h0, st, e);
		chk(st[ST_PEND_LSB], 1);
		chk({mainNm1, boostEn[0]}, 12'h000);
		refRun <= 3'h7;
		waitBoost(0, 200, ok);
		chk(ok, 1);
		chk({mainNm1, mainNm2, switchLowZ[0]}, 17'h048D5);
		countBoost(0, k);
		chk(k, 3);
		chk(switchLowZ[0], 0);
		apb(1'b0, OFF_STATUS, 32'h0, st, e);
		chk(st[ST_PEND_LSB], 0);
		// Device word alone never restarts main
		prog3(3'h7, 2'h0, 6'h00);
		waitBoost(0, 100, ok);
		chk(ok, 0);
		// Aux time set; frequency word alone starts nothing
		wr(OFF_WORD1, 32'd2 << G_LSB);
		wr(OFF_STROBE, 32'h0);
		waitBoost(1, 100, ok);
		chk(ok, 0);
		prog3(3'h1, 2'h0, 6'h00);
		// One aux at a time; the references run in phase
		for (int i = 1; i < 3; i++) begin
			prog3((i == 1) ? 3'h3 : 3'h7, 2'h0, 6'h00);
			waitBoost(i, 200, ok);
			chk(ok, 1);
			chk({switchLowZ[i], boostEn[3 - i]}, 2'h2);
			countBoost(i, k);
			chk(k, 2);
		end
		// Enable already one gives no speed-up
		prog3(3'h7, 2'h0, 6'h00);
		waitBoost(1, 100, ok);
		chk(ok, 0);
		end_sim();
	end
endmodule : synth_lock_speedup_control_test

// ===== rtl/slsc_pkg.sv
package slsc_pkg;
	// ------------------------------------------------------------
	// Word layout
	// ------------------------------------------------------------
	localparam int WORD_W = 22;
	localparam logic [WORD_W-1:0] WORD_RST = 22'h000000;
	// Word 0: main loop
	localparam int A_LSB = 0;
	localparam int A_W = 5;
	localparam int B_LSB = 5;
	localparam int B_W = 11;
	localparam int C_LSB = 16;
	localparam int TIME_W = 6;
	// Word 1: auxiliary-1 plus shared aux controls
	localparam int F_LSB = 14;
	localparam int G_LSB = 16;
	// Word 2: auxiliary-2
	localparam int K_LSB = 14;
	// Word 3: device control
	localparam int R_POS = 11;
	localparam int S_POS = 12;
	localparam int T_POS = 13;
	localparam int U_LSB = 14;
	localparam int V_LSB = 16;
	localparam int V_EXT = 21;
	// ------------------------------------------------------------
	// APB map (byte addresses)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFF_WORD0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_WORD1 = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_WORD2 = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_WORD3 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_STROBE = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h14;
	// Status fields
	localparam int ST_ACT_LSB = 0;
	localparam int ST_PEND_LSB = 4;
	localparam int ST_DIRTY_LSB = 8;
	// ------------------------------------------------------------
	// Lock select and test routes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SLSC_LK_MAIN = 2'b00,
		SLSC_LK_AUX1 = 2'b01,
		SLSC_LK_AUX2 = 2'b10,
		SLSC_LK_AND = 2'b11
	} slsc_lksel_t;
	localparam logic [4:0] TM_M_PRE = 5'h05;
	localparam logic [4:0] TM_M_C11 = 5'h06;
	localparam logic [4:0] TM_M_C5 = 5'h07;
	localparam logic [4:0] TM_M_DN = 5'h19;
	localparam logic [4:0] TM_M_UP = 5'h1A;
	localparam logic [4:0] TM_M_TMR = 5'h1B;
	localparam logic [4:0] TM_A1_PRE = 5'h15;
	localparam logic [4:0] TM_A1_C11 = 5'h16;
	localparam logic [4:0] TM_A1_C3 = 5'h17;
	localparam logic [4:0] TM_A1_DN = 5'h0D;
	localparam logic [4:0] TM_A1_UP = 5'h0E;
	localparam logic [4:0] TM_A1_TMR = 5'h0F;
	localparam logic [4:0] TM_A2_PRE = 5'h1D;
	localparam logic [4:0] TM_A2_C11 = 5'h1E;
	localparam logic [4:0] TM_A2_C3 = 5'h1F;
	localparam logic [4:0] TM_A2_DN = 5'h11;
	localparam logic [4:0] TM_A2_UP = 5'h12;
	localparam logic [4:0] TM_A2_TMR = 5'h13;
	localparam logic [4:0] TM_REF_M = 5'h09;
	localparam logic [4:0] TM_REF_A1 = 5'h0A;
	localparam logic [4:0] TM_REF_A2 = 5'h0B;
endpackage : slsc_pkg

// ===== rtl/slsc_top.sv
`timescale 1ns/10ps
module slsc_top
	import slsc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Loop pins: {up, down, small cnt, 11-bit cnt, prescaler}
	input wire logic [4:0] mainTap,
	input wire logic [4:0] aux1Tap,
	input wire logic [4:0] aux2Tap,
	// Reference pulses and lock detectors: {aux2, aux1, main}
	input wire logic [2:0] refIn,
	input wire logic [2:0] lockIn,
	// Lock and test output
	output logic lockIndicatorOut,
	// Main prescaler coefficients as loaded
	output logic [B_W-1:0] mainNm1,
	output logic [A_W-1:0] mainNm2,
	// Speed-up controls: {aux2, aux1, main}
	output logic [2:0] switchLowZ,
	output logic [2:0] boostEn,
	// Current ratios, one-hot 1/2/4/8
	output logic [3:0] mainRatio,
	output logic [3:0] auxRatio,
	// Power and counter source
	output logic [2:0] powerEn,
	output logic extPulseMode
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] ratioOf(input logic [1:0] code);
		ratioOf = 4'h1 << code;
	endfunction : ratioOf

	logic [WORD_W-1:0] tmpWord [4];
	logic [WORD_W-1:0] opWord [4];
	logic [3:0] dirty;
	logic [2:0] pend;
	logic [2:0] spActive;
	logic [TIME_W-1:0] spCnt [3];
	logic [20:0] syncA;
	logic [20:0] syncB;
	logic [2:0] refPrev;
	logic [2:0] refPulse;
	logic [4:0] mTap;
	logic [4:0] a1Tap;
	logic [4:0] a2Tap;
	logic [2:0] refS;
	logic [2:0] lockS;
	logic wrEn;
	logic commit;
	logic mapped;
	logic [2:0] curEn;
	logic [2:0] newEn;
	logic lockAnd;
	logic next_lock;
	logic [4:0] testCode;
	slsc_lksel_t lockSel;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Pins run off other clocks; only syncB is read downstream
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			syncA <= '0;
			syncB <= '0;
			refPrev <= '0;
		end else begin
			syncA <= {lockIn, refIn, aux2Tap, aux1Tap, mainTap};
			syncB <= syncA;
			refPrev <= syncB[17:15];
		end
	end

	assign mTap = syncB[4:0];
	assign a1Tap = syncB[9:5];
	assign a2Tap = syncB[14:10];
	assign refS = syncB[17:15];
	assign lockS = syncB[20:18];
	// One-cycle enable per rising reference edge
	assign refPulse = refS & ~refPrev;

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// Zero wait states; read data latched in the setup cycle
	assign pready = 1'b1;
	assign wrEn = psel && penable && pwrite && mapped;
	assign commit = wrEn && (paddr == OFF_STROBE);
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		mapped = 1'b0;
		if (paddr <= OFF_STATUS && paddr[1:0] == 2'b00) begin
			mapped = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= '0;
			if (paddr < OFF_STROBE && paddr[1:0] == 2'b00) begin
				prdata[WORD_W-1:0] <= tmpWord[paddr[3:2]];
			end else if (paddr == OFF_STATUS) begin
				prdata[ST_ACT_LSB +: 3] <= spActive;
				prdata[ST_PEND_LSB +: 3] <= pend;
				prdata[ST_DIRTY_LSB +: 4] <= dirty;
			end
		end
	end

	// ------------------------------------------------------------
	// Holding and operating words
	// ------------------------------------------------------------
	// Words wait in holding registers until the strobe write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dirty <= '0;
			for (int k = 0; k < 4; k++) begin
				tmpWord[k] <= WORD_RST;
				opWord[k] <= WORD_RST;
			end
		end else if (commit) begin
			for (int k = 0; k < 4; k++) begin
				if (dirty[k]) begin
					opWord[k] <= tmpWord[k];
				end
			end
			dirty <= '0;
		end else if (wrEn && paddr < OFF_STROBE) begin
			tmpWord[paddr[3:2]] <= pwdata[WORD_W-1:0];
			dirty[paddr[3:2]] <= 1'b1;
		end
	end

	assign curEn = {opWord[3][T_POS], opWord[3][S_POS], opWord[3][R_POS]};
	assign newEn = {tmpWord[3][T_POS], tmpWord[3][S_POS],
		tmpWord[3][R_POS]};
	assign powerEn = curEn;
	assign extPulseMode = opWord[3][V_EXT];
	assign testCode = opWord[3][V_LSB +: 5];
	assign lockSel = slsc_lksel_t'(opWord[3][U_LSB +: 2]);

	// ------------------------------------------------------------
	// Speed-up requests, counters and prescaler load
	// ------------------------------------------------------------
	// Requests wait for the loop's reference; a new strobe wins
	// over a reference that serves the old one in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (refPulse[i]) begin
					pend[i] <= 1'b0;
				end
			end
			if (commit && dirty[0]) begin
				pend[0] <= 1'b1;
			end
			for (int i = 1; i < 3; i++) begin
				if (commit && dirty[3] && newEn[i] && !curEn[i]) begin
					pend[i] <= 1'b1;
				end
			end
		end
	end

	// One counter per loop, each on its own reference pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spActive <= '0;
			for (int i = 0; i < 3; i++) begin
				spCnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (refPulse[i] && pend[i]) begin
					// Main from C, both aux from shared G
					spCnt[i] <= (i == 0) ? opWord[0][C_LSB +: TIME_W]
						: opWord[1][G_LSB +: TIME_W];
					spActive[i] <= (i == 0)
						? (opWord[0][C_LSB +: TIME_W] != '0)
						: (opWord[1][G_LSB +: TIME_W] != '0);
				end else if (refPulse[i] && spActive[i]) begin
					spCnt[i] <= spCnt[i] - 1'b1;
					if (spCnt[i] == 6'h01) begin
						spActive[i] <= 1'b0;
					end
				end
			end
		end
	end

	// Switch and boost share the active flag so they never skew
	assign switchLowZ = spActive;
	assign boostEn = spActive;

	// Prescaler takes new coefficients only on a main reference
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mainNm1 <= '0;
			mainNm2 <= '0;
		end else if (refPulse[0] && pend[0]) begin
			mainNm1 <= opWord[0][B_LSB +: B_W];
			mainNm2 <= opWord[0][A_LSB +: A_W];
		end
	end

	// Current ratios
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mainRatio <= 4'h1;
			auxRatio <= 4'h1;
		end else begin
			mainRatio <= ratioOf(opWord[1][F_LSB +: 2]);
			auxRatio <= ratioOf(opWord[2][K_LSB +: 2]);
		end
	end

	// ------------------------------------------------------------
	// Lock output and test routing
	// ------------------------------------------------------------
	// Disabled loops drop out; all off forces the output low
	assign lockAnd = (lockS[0] | ~curEn[0]) & (lockS[1] | ~curEn[1])
		& (lockS[2] | ~curEn[2]) & (|curEn);

	// Reserved test codes fall back to normal lock select
	always_comb begin
		case (testCode)
			TM_M_PRE, TM_M_C11, TM_M_C5: next_lock = mTap[testCode[1:0]-2'd1];
			TM_M_DN: next_lock = mTap[3];
			TM_M_UP: next_lock = mTap[4];
			TM_M_TMR: next_lock = spActive[0];
			TM_A1_PRE, TM_A1_C11, TM_A1_C3: next_lock = a1Tap[testCode[1:0]-2'd1];
			TM_A1_DN: next_lock = a1Tap[3];
			TM_A1_UP: next_lock = a1Tap[4];
			TM_A1_TMR: next_lock = spActive[1];
			TM_A2_PRE, TM_A2_C11, TM_A2_C3: next_lock = a2Tap[testCode[1:0]-2'd1];
			TM_A2_DN: next_lock = a2Tap[3];
			TM_A2_UP: next_lock = a2Tap[4];
			TM_A2_TMR: next_lock = spActive[2];
			TM_REF_M: next_lock = refS[0];
			TM_REF_A1: next_lock = refS[1];
			TM_REF_A2: next_lock = refS[2];
			default: begin
				case (lockSel)
					SLSC_LK_MAIN: next_lock = lockS[0];
					SLSC_LK_AUX1: next_lock = lockS[1];
					SLSC_LK_AUX2: next_lock = lockS[2];
					SLSC_LK_AND: next_lock = lockAnd;
					default: next_lock = 1'b0;
				endcase
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lockIndicatorOut <= 1'b0;
		end else begin
			lockIndicatorOut <= next_lock;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	lock_main_a: assert property (
		testCode == 5'h00 && lockSel == SLSC_LK_MAIN
		|=> lockIndicatorOut == $past(lockS[0]))
		else $error("main lock not routed");
	lock_none_a: assert property (
		testCode == 5'h00 && lockSel == SLSC_LK_AND && curEn == 3'b000
		|=> !lockIndicatorOut)
		else $error("AND lock high with all loops off");
	route_main_a: assert property (
		testCode == TM_M_UP |=> lockIndicatorOut == $past(mTap[4]))
		else $error("main up pulse not routed");
	route_aux1_a: assert property (
		testCode == TM_A1_TMR |=> lockIndicatorOut == $past(spActive[1]))
		else $error("aux-1 timer not routed");
	route_aux2_a: assert property (
		testCode == TM_A2_PRE |=> lockIndicatorOut == $past(a2Tap[0]))
		else $error("aux-2 prescaler not routed");
	route_ref_a: assert property (
		testCode == TM_REF_A1 |=> lockIndicatorOut == $past(refS[1]))
		else $error("aux-1 reference not routed");
	main_load_a: assert property (
		refPulse[0] && pend[0] && !(commit && dirty[0])
		|=> mainNm1 == $past(opWord[0][B_LSB +: B_W]) && !pend[0])
		else $error("main prescaler not loaded");
	boost_on_a: assert property (
		refPulse[0] && pend[0] && opWord[0][C_LSB +: TIME_W] != '0
		|=> boostEn[0] && switchLowZ[0])
		else $error("main speed-up not started");
	boost_off_a: assert property (
		refPulse[0] && !pend[0] && spActive[0] && spCnt[0] == 6'h01
		|=> !boostEn[0] && !switchLowZ[0])
		else $error("main speed-up not ended at zero");
	aux_start_a: assert property (
		commit && dirty[3] && newEn[1] && !curEn[1] |=> pend[1])
		else $error("aux-1 enable edge not requested");
	aux_hold_a: assert property (
		spActive[1] && !refPulse[1] |=> spActive[1] && $stable(spCnt[1]))
		else $error("aux-1 counter moved without reference");
	ratio_a: assert property (
		opWord[1][F_LSB +: 2] == 2'b11 |=> mainRatio == 4'h8)
		else $error("main ratio code 11 not 8");

	main_run_c: cover property (spActive[0] ##[1:300] !spActive[0]);
	aux_run_c: cover property (pend[2] ##1 spActive[2]);
	and_lock_c: cover property (lockSel == SLSC_LK_AND && lockAnd);
	ext_mode_c: cover property (extPulseMode && testCode == TM_M_C11);
endmodule : slsc_top
